// ### bench/tb_top.sv
// self-checking bench for the duplicate-tracking table value registers
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import hdt_pkg::*;

	// ======================================================================
	// stimulus and observation
	logic                clk_i   = 1'b0;
	logic                rst_n_i = 1'b0;
	logic [ADDR_W-1:0]   addr_i  = '0;
	logic [DATA_W-1:0]   wdata_i = '0;
	logic                we_i    = 1'b0;
	logic                re_i    = 1'b0;
	logic [DATA_W-1:0]   rdata_o;
	logic                busy_o;
	int                  error_cnt = 0;
	int                  checked   = 0;
	logic [31:0]         pat [7];   // entry image pushed through the table

	// one row: address, value written, value read back
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_t;
	row_t rows [11] = '{
		'{12'h454, 32'hffffffff, 32'h9c00000f},   // reserved bits of flags read zero
		'{12'h454, 32'h80000000, 32'h80000000},
		'{12'h458, 32'ha5a5c33c, 32'ha5a5c33c},
		'{12'h45c, 32'h1234abcd, 32'h1234abcd},
		'{12'h460, 32'h89abcdef, 32'h89abcdef},
		'{12'h464, 32'hffff0001, 32'hffff0001},
		'{12'h468, 32'h0001ffff, 32'h0001ffff},
		'{12'h46c, 32'h7ffe8001, 32'h7ffe8001},
		'{12'h444, 32'hffff1234, 32'hffff1234},   // index registers keep every bit
		'{12'h448, 32'h13579bdf, 32'h13579bdf},
		'{12'h47c, 32'h5a5a5a5a, 32'h00000000}    // unmapped: write dropped
	};

	hdt_value_regs DUT (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.addr_i  (addr_i),
		.wdata_i (wdata_i),
		.we_i    (we_i),
		.re_i    (re_i),
		.rdata_o (rdata_o),
		.busy_o  (busy_o)
	);

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	// ======================================================================
	// bus tasks and compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe, released at the following edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		we_i    <= 1'b1;
		@(posedge clk_i);
		we_i    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		re_i   <= 1'b1;
		@(posedge clk_i);
		re_i   <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	// bounded wait on the self-clearing start bit; a search takes 257 cycles
	task automatic wait_idle;
		int n;
		#1;
		for (n = 0; n < 400 && busy_o !== 1'b0; n++) begin
			@(posedge clk_i);
			#1;
		end
		chk({31'h0, busy_o}, 32'h0);
	endtask

	task automatic results;
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ======================================================================
	// watchdog: whole sequence needs well under 2000 cycles
	initial begin
		#(25 * 5000);
		error_cnt++;
		results();
	end

	// ======================================================================
	// main sequence
	initial begin
		pat = '{32'h9400000a, 32'h12345605, 32'hc0de1234, 32'hdeadbeef,
			32'h00100020, 32'h00100020, 32'h00030004};
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		// every value word starts at zero
		for (int i = 0; i < 7; i++) begin
			rd(12'h454 + 12'(4 * i), 32'h0);
		end
		// ordinary cases: write each word, read it straight back
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		// read data fall back to zero one cycle later
		@(posedge clk_i);
		#1;
		chk(rdata_o, 32'h0);
		// direct write of an entry at table address 5
		for (int i = 0; i < 7; i++) begin
			wr(12'h454 + 12'(4 * i), pat[i]);
		end
		wr(OFS_ACCESS_CTRL, 32'h00000085);
		#1;
		chk({31'h0, busy_o}, 32'h1);
		wait_idle();
		// scribble the words, keeping the direct address, then read back
		for (int i = 0; i < 7; i++) begin
			if (i != 1) begin
				wr(12'h454 + 12'(4 * i), 32'h0);
			end
		end
		wr(OFS_ACCESS_CTRL, 32'h00000086);
		wait_idle();
		for (int i = 0; i < 7; i++) begin
			rd(12'h454 + 12'(4 * i), pat[i]);
		end
		rd(OFS_ACCESS_CTRL, 32'h00000006);
		// search: one static entry in the whole table
		wr(OFS_ACCESS_CTRL, 32'h00000083);
		wr(OFS_ACCESS_CTRL, 32'h00000006);
		wait_idle();
		rd(OFS_ACCESS_CTRL, 32'h00010023);
		// no operation clears start without touching the words
		wr(OFS_ACCESS_CTRL, 32'h00000080);
		wait_idle();
		rd(OFS_ACCESS_CTRL, 32'h00000000);
		rd(OFS_SRC_MAC_LOW, pat[3]);
		// hashed key: store under the MAC key, scribble, find it again
		wr(OFS_SRC_MAC_LOW, 32'h0f1e2d3c);
		wr(OFS_ACCESS_CTRL, 32'h00000081);
		wait_idle();
		wr(OFS_SRC_MAC_LOW, 32'h0);
		wr(OFS_ENTRY_FLAGS, 32'h0);
		wr(OFS_ACCESS_CTRL, 32'h00000082);
		wait_idle();
		rd(OFS_SRC_MAC_LOW, 32'h0f1e2d3c);
		rd(OFS_ENTRY_FLAGS, pat[0]);
		// reset in mid-run clears words and control
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(OFS_ENTRY_FLAGS, 32'h0);
		rd(OFS_MISSEQUENCE_COUNTS, 32'h0);
		rd(OFS_ACCESS_CTRL, 32'h0);
		results();
	end
endmodule

// ### src/hdt_pkg.sv
// constants and types shared by the duplicate-tracking table value registers
package hdt_pkg;

	// ======================================================================
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int WORDS  = 7;
	localparam int DEPTH  = 256;

	// ======================================================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFS_INDEX_SRC_HIGH       = 12'h444;
	localparam logic [11:0] OFS_INDEX_SRC_LOW        = 12'h448;
	localparam logic [11:0] OFS_ACCESS_CTRL          = 12'h450;
	localparam logic [11:0] OFS_ENTRY_FLAGS          = 12'h454;
	localparam logic [11:0] OFS_DEST_MAC_HIGH        = 12'h458;
	localparam logic [11:0] OFS_DEST_LOW_SRC_HIGH    = 12'h45c;
	localparam logic [11:0] OFS_SRC_MAC_LOW          = 12'h460;
	localparam logic [11:0] OFS_FIRST_SEQ_NUMBERS    = 12'h464;
	localparam logic [11:0] OFS_EXPECTED_SEQ_NUMBERS = 12'h468;
	localparam logic [11:0] OFS_MISSEQUENCE_COUNTS   = 12'h46c;

	// ======================================================================
	// field positions
	localparam int POS_STATIC     = 31;
	localparam int POS_AGE_LSB    = 26;
	localparam int POS_START      = 7;
	localparam int POS_VALID      = 6;
	localparam int POS_VALID_END  = 5;
	localparam int POS_DIRECT     = 2;
	localparam int POS_VCOUNT_LSB = 16;

	// writable bits of the entry flags word: static, age, path
	localparam logic [31:0] MASK_ENTRY_FLAGS = 32'h9c00000f;

	// ======================================================================
	// reset values
	localparam logic [31:0] RST_WORD   = 32'h00000000;
	localparam logic [13:0] RST_VCOUNT = 14'h0000;

	// ======================================================================
	// access actions
	typedef enum logic [1:0] {
		HDT_ACT_NOP    = 2'b00,
		HDT_ACT_WRITE  = 2'b01,
		HDT_ACT_READ   = 2'b10,
		HDT_ACT_SEARCH = 2'b11
	} hdt_action_t;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		HDT_IDLE = 2'b01,
		HDT_SCAN = 2'b10
	} hdt_state_t;

endpackage

// ### src/hdt_value_regs.sv
// value registers, index and access control of the duplicate-tracking table
//
// Local design decision: the strobed register port.
module hdt_value_regs (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	// register port
	input  wire logic [hdt_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [hdt_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                        we_i,
	input  wire logic                        re_i,
	output logic      [hdt_pkg::DATA_W-1:0]  rdata_o,
	// status
	output logic                             busy_o
);
	import hdt_pkg::*;

	// ======================================================================
	// reset release
	logic [1:0] rst_sync;    // two-stage release of the async reset
	logic       rst_n;       // reset used by the rest of the block

	// assert asynchronously, release on the clock
	// a synchronous release keeps every state flop clear of a late reset edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ======================================================================
	// state
	// the table sits in the state struct so one process owns all flops but the reset release;
	// a real build would map it to a memory and give up the reset clear
	typedef struct packed {
		logic [DEPTH-1:0][WORDS-1:0][31:0] tbl;  // tracking table
		logic [WORDS-1:0][31:0]            val;  // value words
		logic [31:0]                       idx1; // source MAC high index
		logic [31:0]                       idx2; // source MAC low index
		logic [1:0]                        action;
		logic                              direct;
		logic                              start;
		logic                              valid;
		logic                              vend;   // valid entry or end
		logic [13:0]                       vcount; // valid entries
		hdt_state_t                        st;
		logic [7:0]                        ptr;    // scan pointer
		logic [8:0]                        cnt;    // scan tally
		logic [31:0]                       rdata;
	} hdt_regs_t;

	hdt_regs_t s;       // registered state
	hdt_regs_t next_s;  // next state

	// ======================================================================
	// helpers

	// fold the 96-bit key into a table index
	// cheap and always in range; distinct keys may share an index,
	// in which case the later write simply replaces the earlier entry
	function automatic logic [7:0] hdt_hash(input logic [95:0] key);
		logic [7:0] h;
		h = 8'h00;
		for (int i = 0; i < 12; i++) begin
			h = h ^ key[i*8 +: 8];
		end
		return h;
	endfunction

	// decode a value-word address: hit flag and word number
	function automatic logic [3:0] hdt_val_slot(input logic [11:0] a);
		logic [11:0] d;
		d = a - OFS_ENTRY_FLAGS;
		if (a >= OFS_ENTRY_FLAGS && a <= OFS_MISSEQUENCE_COUNTS && a[1:0] == 2'b00) begin
			return {1'b1, d[4:2]};
		end
		return 4'h0;
	endfunction

	logic [3:0]        wr_slot;   // decoded write target
	logic [3:0]        rd_slot;   // decoded read target
	logic [7:0]        acc_idx;   // entry addressed by an access
	logic [WORDS-1:0][31:0] cur_entry; // entry at acc_idx
	logic [31:0]       ctrl_word; // access control as read back

	assign wr_slot = hdt_val_slot(addr_i);
	assign rd_slot = hdt_val_slot(addr_i);

	// direct address wins over the hashed key
	// the upper half of index register one is kept for software only
	assign acc_idx = s.direct ? s.val[1][7:0]
		: hdt_hash({s.val[1], s.val[2][31:16], s.idx1[15:0], s.idx2});
	assign cur_entry = s.tbl[acc_idx];

	assign ctrl_word = {2'b00, s.vcount, 8'h00, s.start, s.valid, s.vend,
		2'b00, s.direct, s.action};

	// ======================================================================
	// next-state logic
	always_comb begin
		next_s = s;
		// read data stands only in the cycle after the strobe
		next_s.rdata = RST_WORD;

		// software reads
		if (re_i) begin
			if (rd_slot[3]) begin
				next_s.rdata = s.val[rd_slot[2:0]];
			end else begin
				case (addr_i)
					OFS_INDEX_SRC_HIGH: begin
						next_s.rdata = s.idx1;
					end
					OFS_INDEX_SRC_LOW: begin
						next_s.rdata = s.idx2;
					end
					OFS_ACCESS_CTRL: begin
						next_s.rdata = ctrl_word;
					end
					default: begin
						// unmapped reads return zero
						next_s.rdata = RST_WORD;
					end
				endcase
			end
		end

		// software writes
		if (we_i) begin
			if (wr_slot[3]) begin
				// reserved flag bits stay zero
				if (wr_slot[2:0] == 3'd0) begin
					next_s.val[0] = wdata_i & MASK_ENTRY_FLAGS;
				end else begin
					// full-width words, every bit kept
					next_s.val[wr_slot[2:0]] = wdata_i;
				end
			end else begin
				case (addr_i)
					OFS_INDEX_SRC_HIGH: begin
						next_s.idx1 = wdata_i;
					end
					OFS_INDEX_SRC_LOW: begin
						next_s.idx2 = wdata_i;
					end
					OFS_ACCESS_CTRL: begin
						// a running access may not be retargeted
						if (!s.start) begin
							next_s.action = wdata_i[1:0];
							next_s.direct = wdata_i[POS_DIRECT];
							next_s.valid  = wdata_i[POS_VALID];
							next_s.start  = wdata_i[POS_START];
							next_s.vcount = wdata_i[POS_VCOUNT_LSB +: 14];
							if (wdata_i[POS_START]) begin
								next_s.vend = 1'b0;
							end
						end
					end
					default: begin
						// writes to unmapped offsets are dropped
					end
				endcase
			end
		end

		// table sequencer; its loads win over a same-cycle software write
		// write, read and no operation take one cycle; a search takes 1 + 256
		case (s.st)
			HDT_IDLE: begin
				if (s.start) begin
					case (s.action)
						HDT_ACT_WRITE: begin
							// whole entry copied, sequence words verbatim
							next_s.tbl[acc_idx] = s.val;
							next_s.start = 1'b0;
						end
						HDT_ACT_READ: begin
							// load all words in the same edge as the clear
							next_s.val   = cur_entry;
							next_s.start = 1'b0;
						end
						HDT_ACT_SEARCH: begin
							next_s.st  = HDT_SCAN;
							next_s.ptr = 8'h00;
							next_s.cnt = 9'h000;
						end
						default: begin
							// no operation, finish at once
							next_s.start = 1'b0;
						end
					endcase
				end
			end
			HDT_SCAN: begin
				// one entry per cycle, static entries are the valid ones
				if (s.tbl[s.ptr][0][POS_STATIC]) begin
					next_s.cnt = 9'(s.cnt + 9'h001);
				end
				next_s.ptr = 8'(s.ptr + 8'h01);
				if (s.ptr == 8'hff) begin
					next_s.vcount = {5'h00, s.tbl[s.ptr][0][POS_STATIC]
						? 9'(s.cnt + 9'h001) : s.cnt};
					next_s.vend   = 1'b1;
					next_s.start  = 1'b0;
					next_s.st     = HDT_IDLE;
				end
			end
			default: begin
				// illegal code, recover to idle
				next_s.st = HDT_IDLE;
			end
		endcase
	end

	// ======================================================================
	// state register
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s        <= '0;
			s.vcount <= RST_VCOUNT;
			s.st     <= HDT_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ======================================================================
	// outputs
	assign rdata_o = s.rdata;
	assign busy_o  = s.start;

	// ======================================================================
	// checks
	// one clock domain; every check rests while the internal reset holds
	default clocking hdt_cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	logic idle_go;  // an access begins this cycle
	assign idle_go = s.start && s.st == HDT_IDLE;

	start_self_clear_a: assert property (
		idle_go && s.action != HDT_ACT_SEARCH |=> !s.start)
		else $error("start did not clear after access");

	read_load_a: assert property (
		idle_go && s.action == HDT_ACT_READ |=> s.val == $past(cur_entry))
		else $error("read access did not load value words");

	write_store_a: assert property (
		idle_go && s.action == HDT_ACT_WRITE
		|=> s.tbl[$past(acc_idx)] == $past(s.val))
		else $error("write access did not store entry");

	direct_index_a: assert property (
		s.direct |-> acc_idx == s.val[1][7:0])
		else $error("direct access ignores direct address");

	flags_reserved_a: assert property (
		re_i && addr_i == OFS_ENTRY_FLAGS
		|=> (rdata_o & ~MASK_ENTRY_FLAGS) == 32'h00000000)
		else $error("reserved flag bits not zero");

	static_write_a: assert property (
		we_i && addr_i == OFS_ENTRY_FLAGS && !s.start
		|=> s.val[0][POS_STATIC] == $past(wdata_i[POS_STATIC]))
		else $error("static flag not written");

	search_time_a: assert property (
		idle_go && s.action == HDT_ACT_SEARCH
		|=> s.start [*8] ##[248:250] !s.start && s.vend)
		else $error("search did not finish in one table pass");

	nop_stable_a: assert property (
		idle_go && s.action == HDT_ACT_NOP && !we_i
		|=> !s.start && $stable(s.val))
		else $error("no-operation access changed state");

	read_only_once_a: assert property (
		!re_i |=> rdata_o == 32'h00000000)
		else $error("read data outside its cycle");

	// a busy access keeps its target; a retargeting write is dropped
	ctrl_locked_a: assert property (
		we_i && addr_i == OFS_ACCESS_CTRL && s.start
		|=> $stable(s.action) && $stable(s.direct))
		else $error("access control changed while busy");

	// the scan only runs while the start bit shows an access
	scan_busy_a: assert property (
		s.st == HDT_SCAN |-> s.start)
		else $error("table scan without start bit");

	// the end flag is raised by the last step of a search only
	vend_scan_a: assert property (
		$rose(s.vend) |-> $past(s.st) == HDT_SCAN && !s.start)
		else $error("search end flag outside a search");

	// the static flag reads back as held
	flags_read_a: assert property (
		re_i && addr_i == OFS_ENTRY_FLAGS
		|=> rdata_o[POS_STATIC] == $past(s.val[0][POS_STATIC]))
		else $error("static flag read back wrong");

	// the lower source MAC word reads back as held
	src_low_read_a: assert property (
		re_i && addr_i == OFS_SRC_MAC_LOW |=> rdata_o == $past(s.val[3]))
		else $error("source MAC low word read wrong");

	// sequence words go into the entry untouched, so matching numbers stay matched
	seq_verbatim_a: assert property (
		idle_go && s.action == HDT_ACT_WRITE
		|=> s.tbl[$past(acc_idx)][4] == $past(s.val[4])
		&& s.tbl[$past(acc_idx)][5] == $past(s.val[5]))
		else $error("sequence words altered on store");

	// offsets outside the map read as zero
	unmapped_zero_a: assert property (
		re_i && !rd_slot[3] && addr_i != OFS_INDEX_SRC_HIGH
		&& addr_i != OFS_INDEX_SRC_LOW && addr_i != OFS_ACCESS_CTRL
		|=> rdata_o == 32'h00000000)
		else $error("unmapped offset read not zero");

endmodule
